/* File: dv/ahes_top_asserts.sv */
`timescale 1ns/100ps
`include "ahes_defs.vh"
module ahes_chk #(
    parameter [23:0] SEC_TICKS = 24'h00000A,
    parameter [23:0] LB_DETECT_CYC = 24'h000008
) (
    input wire I_CLK,
    input wire I_RESETN,
    input wire [7:0] I_ADDR,
    input wire I_RD,
    input wire [7:0] O_RDATA,
    input wire O_INT,
    input wire I_TX_SLIP_POS,
    input wire I_TX_SLIP_NEG,
    input wire I_CH2_RX_BYTE,
    input wire I_CH2_RX_END,
    input wire I_CH2_RX_FIFO_FULL,
    input wire O_CH2_RX_STORE,
    input wire I_CH2_TX_NEED_BYTE,
    input wire I_CH2_TX_FIFO_EMPTY,
    input wire I_CH2_TX_LAST_BIT,
    input wire O_CH2_TX_ABORT,
    input wire O_CH2_TX_ENABLE
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);
    // no event input may set a bit of the second register in the first read cycle
    wire quiet = !(I_TX_SLIP_POS || I_TX_SLIP_NEG || I_CH2_RX_BYTE || I_CH2_RX_END
        || I_CH2_TX_NEED_BYTE || I_CH2_TX_LAST_BIT);
    wire rd_slip = I_RD && (I_ADDR == `AHES_ADDR_SLIP_CH2_STAT);
    wire rd_sum = I_RD && (I_ADDR == `AHES_ADDR_SUMMARY);
    reg under_ff;
    always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) under_ff <= 1'b0;
        else under_ff <= I_CH2_TX_NEED_BYTE && I_CH2_TX_FIFO_EMPTY && O_CH2_TX_ENABLE;
    end
    sequence s_two_reads;
        (rd_slip && quiet) ##1 rd_slip;
    endsequence
    sequence s_abort_then_idle;
        O_CH2_TX_ABORT ##1 !O_CH2_TX_ABORT;
    endsequence
    a_store_gate: assert property (O_CH2_RX_STORE ==
        (I_CH2_RX_BYTE && !I_CH2_RX_FIFO_FULL))
        else $error("receive store strobe wrong");
    a_abort_cause: assert property (O_CH2_TX_ABORT |-> under_ff)
        else $error("abort without underrun");
    a_abort_disables: assert property (O_CH2_TX_ABORT |-> !O_CH2_TX_ENABLE)
        else $error("transmitter enabled at abort");
    a_abort_single: assert property (O_CH2_TX_ABORT |-> s_abort_then_idle)
        else $error("abort longer than one cycle");
    a_enable_resume: assert property ($rose(O_CH2_TX_ENABLE) |-> $past(rd_slip))
        else $error("transmitter enabled without status read");
    a_summary_int: assert property (rd_sum |=>
        ((O_RDATA[3] || O_RDATA[4]) == $past(O_INT)) && O_RDATA[7:5] == 3'h0 &&
        O_RDATA[2:0] == 3'h0)
        else $error("summary disagrees with interrupt");
    a_read_clear: assert property (s_two_reads |=> O_RDATA == 8'h00)
        else $error("status not cleared by read");
    a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
        else $error("read data outside answer cycle");
endmodule
bind ahes_top ahes_chk #(.SEC_TICKS(SEC_TICKS), .LB_DETECT_CYC(LB_DETECT_CYC)) ahes_chk_i (
    .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_ADDR(I_ADDR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .O_INT(O_INT), .I_TX_SLIP_POS(I_TX_SLIP_POS), .I_TX_SLIP_NEG(I_TX_SLIP_NEG),
    .I_CH2_RX_BYTE(I_CH2_RX_BYTE), .I_CH2_RX_END(I_CH2_RX_END),
    .I_CH2_RX_FIFO_FULL(I_CH2_RX_FIFO_FULL), .O_CH2_RX_STORE(O_CH2_RX_STORE),
    .I_CH2_TX_NEED_BYTE(I_CH2_TX_NEED_BYTE), .I_CH2_TX_FIFO_EMPTY(I_CH2_TX_FIFO_EMPTY),
    .I_CH2_TX_LAST_BIT(I_CH2_TX_LAST_BIT), .O_CH2_TX_ABORT(O_CH2_TX_ABORT),
    .O_CH2_TX_ENABLE(O_CH2_TX_ENABLE)
);

/* File: dv/alarm_hdlc_event_status_tb.sv */
`timescale 1ns/100ps
`include "ahes_defs.vh"
module alarm_hdlc_event_status_tb;
    reg i_clk = 1'b0;
    reg i_resetn = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [7:0] wdata = 8'h00;
    reg wr = 1'b0, rd = 1'b0, tick = 1'b0, lb_ok = 1'b0, alarm = 1'b0, full = 1'b0;
    reg empty = 1'b1;
    reg [5:0] err = 6'h00;
    reg [6:0] hd = 7'h00;
    reg [3:0] slp = 4'h0;
    reg [6:0] level = 7'h00;
    reg [7:0] rx_addr = 8'h00;
    reg [2:0] rx_st = 3'h0;
    reg rd_seen = 1'b0;
    reg [7:0] v = 8'h00;
    reg [7:0] q[$];
    wire [7:0] rdata;
    wire intr, tx_en;
    integer err_count = 0, checks_done = 0, cycles = 0, i;

    always #10 i_clk = ~i_clk;

    ahes_top #(.SEC_TICKS(24'h00000A), .LB_DETECT_CYC(24'h000008)) ahes_top_i (
        .I_CLK(i_clk), .I_RESETN(i_resetn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
        .I_RD(rd), .O_RDATA(rdata), .O_INT(intr), .I_RX_LINE_TICK(tick), .I_LFA(err[0]),
        .I_FER(err[1]), .I_CER(err[2]), .I_AIS(err[3]), .I_LOS(err[4]), .I_CVE(err[5]),
        .I_LB_PATTERN_OK(lb_ok), .I_PRBS_CHANGE(hd[6]), .I_ALARM_SIM(alarm),
        .I_RX_SLIP_NEG(slp[0]), .I_RX_SLIP_POS(slp[1]), .I_TX_SLIP_POS(slp[2]),
        .I_TX_SLIP_NEG(slp[3]), .I_CH2_RX_START(hd[5]), .I_CH2_RX_BYTE(hd[4]),
        .I_CH2_RX_END(hd[3]), .I_CH2_RX_FIFO_FULL(full), .I_CH2_RX_FIFO_LEVEL(level),
        .I_CH2_RX_ADDR(rx_addr), .I_CH2_RX_STATUS(rx_st), .O_CH2_RX_STORE(),
        .I_CH2_TX_NEED_BYTE(hd[2]), .I_CH2_TX_FIFO_EMPTY(empty), .I_CH2_TX_MSG_END_CMD(hd[1]),
        .I_CH2_TX_LAST_BIT(hd[0]), .O_CH2_TX_ABORT(), .O_CH2_TX_ENABLE(tx_en)
    );

    task check(input string nm, input [7:0] seen, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("wrong value %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // strobes stay up between calls so reads can run back to back
    task bus(input w, input [7:0] a, input [7:0] d);
        begin
            wr <= w;
            rd <= !w;
            addr <= a;
            wdata <= d;
            if (!w) q.push_back(d);
            @(posedge i_clk);
        end
    endtask
    task wt(input integer n);
        begin
            wr <= 1'b0;
            rd <= 1'b0;
            repeat (n) @(posedge i_clk);
        end
    endtask
    task pulse(input [5:0] e, input [3:0] s, input [6:0] h);
        begin
            wr <= 1'b0;
            rd <= 1'b0;
            err <= e;
            slp <= s;
            hd <= h;
            @(posedge i_clk);
            err <= 6'h00;
            slp <= 4'h0;
            hd <= 7'h00;
            @(posedge i_clk);
        end
    endtask
    task lv(input [1:0] e);
        begin
            wr <= 1'b0;
            rd <= 1'b0;
            @(negedge i_clk);
            check("int_enable", {6'h00, intr, tx_en}, {6'h00, e});
            @(posedge i_clk);
        end
    endtask
    // timer intervals stay aligned because every run sends exactly ten ticks
    task sec_run;
        begin
            repeat (10) begin
                tick <= 1'b1;
                @(posedge i_clk);
                tick <= 1'b0;
                @(posedge i_clk);
            end
            repeat (3) @(posedge i_clk);
        end
    endtask
    task t_end(input string nm);
        $display("test %0s done", nm);
    endtask
    task close_out;
        begin
            $display("comparisons %0d mismatches %0d", checks_done, err_count);
            if (err_count == 0 && checks_done > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask

    always @(posedge i_clk) rd_seen <= rd;
    always @(negedge i_clk) begin
        if (rd_seen) check("rdata", rdata, q.pop_front());
    end
    always @(posedge i_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            err_count = err_count + 1;
            close_out;
        end
    end

    initial begin
        v = 8'($urandom(10));
        repeat (5) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        for (i = 0; i < 8; i = i + 1) begin
            v = (i == 2 || i == 3) ? `AHES_MASK_RESET : (i == 4) ? `AHES_CFG_RESET : 8'h00;
            bus(0, i[7:0], v);
        end
        bus(0, 8'h3F, 8'h00);
        v = 8'($urandom);
        bus(1, 8'h02, v);
        bus(1, 8'h06, 8'hFF);
        bus(0, 8'h02, v);
        bus(0, 8'h06, 8'h00);
        wt(1);
        t_end("reset_regs");
        pulse(6'h00, 4'h4, 7'h00);
        bus(0, 8'h01, 8'h00);
        bus(1, 8'h04, 8'h05);
        pulse(6'h00, 4'h4, 7'h00);
        lv(2'b01);
        bus(0, 8'h06, 8'h00);
        bus(0, 8'h01, 8'h80);
        bus(0, 8'h01, 8'h00);
        t_end("masked");
        bus(1, 8'h02, 8'h00);
        bus(1, 8'h03, 8'h00);
        bus(1, 8'h04, 8'h04);
        for (i = 0; i < 4; i = i + 1) begin
            pulse(6'h00, 4'h1 << i, 7'h00);
            lv(2'b11);
            bus(0, 8'h06, (i < 2) ? 8'h08 : 8'h10);
            v = (i < 2) ? (8'h02 >> i) : (8'h80 >> (i - 2));
            bus(0, (i < 2) ? 8'h00 : 8'h01, v);
            lv(2'b01);
        end
        alarm <= 1'b1;
        wt(3);
        alarm <= 1'b0;
        wt(2);
        bus(0, 8'h00, 8'h03);
        t_end("slips");
        for (i = 0; i < 7; i = i + 1) begin
            bus(1, 8'h05, 8'h01 << i);
            pulse((i < 6) ? (6'h01 << i) : 6'h00, (i == 6) ? 4'h2 : 4'h0, 7'h00);
            sec_run;
            bus(0, 8'h00, (i == 6) ? 8'hC1 : 8'hC0);
        end
        bus(1, 8'h05, 8'h3E);
        pulse(6'h01, 4'h0, 7'h00);
        sec_run;
        bus(0, 8'h00, 8'h40);
        t_end("seconds");
        lb_ok <= 1'b1;
        wt(6);
        lb_ok <= 1'b0;
        wt(2);
        bus(0, 8'h00, 8'h00);
        lb_ok <= 1'b1;
        wt(12);
        bus(0, 8'h07, 8'h01);
        bus(0, 8'h00, 8'h20);
        lb_ok <= 1'b0;
        wt(2);
        bus(0, 8'h07, 8'h00);
        bus(0, 8'h00, 8'h20);
        bus(1, 8'h04, 8'h06);
        pulse(6'h00, 4'h0, 7'h40);
        bus(0, 8'h00, 8'h20);
        bus(1, 8'h04, 8'h04);
        t_end("loopback");
        v = 8'($urandom);
        rx_addr <= v;
        rx_st <= 3'($urandom);
        level <= 7'($urandom);
        pulse(6'h00, 4'h0, 7'h20);
        pulse(6'h00, 4'h0, 7'h10);
        bus(0, 8'h01, 8'h00);
        pulse(6'h00, 4'h0, 7'h10);
        bus(0, 8'h01, 8'h10);
        bus(0, 8'h0B, v);
        bus(0, 8'h0C, {4'h0, rx_st, 1'b0});
        repeat (29) pulse(6'h00, 4'h0, 7'h10);
        bus(0, 8'h01, 8'h00);
        pulse(6'h00, 4'h0, 7'h10);
        bus(0, 8'h01, 8'h01);
        pulse(6'h00, 4'h0, 7'h08);
        bus(0, 8'h01, 8'h20);
        bus(0, 8'h08, {1'b0, level});
        bus(0, 8'h09, 8'h20);
        bus(0, 8'h0A, 8'h00);
        pulse(6'h00, 4'h0, 7'h20);
        full <= 1'b1;
        pulse(6'h00, 4'h0, 7'h10);
        full <= 1'b0;
        bus(0, 8'h01, 8'h08);
        bus(0, 8'h0C, {3'h0, 1'b1, rx_st, 1'b0});
        pulse(6'h00, 4'h0, 7'h20);
        bus(0, 8'h0C, {4'h0, rx_st, 1'b0});
        t_end("receive");
        pulse(6'h00, 4'h0, 7'h01);
        bus(0, 8'h01, 8'h04);
        pulse(6'h00, 4'h0, 7'h02);
        pulse(6'h00, 4'h0, 7'h04);
        bus(0, 8'h01, 8'h00);
        bus(1, 8'h04, 8'h00);
        pulse(6'h00, 4'h0, 7'h01);
        bus(0, 8'h01, 8'h00);
        pulse(6'h00, 4'h0, 7'h04);
        wt(3);
        lv(2'b10);
        bus(0, 8'h01, 8'h02);
        lv(2'b01);
        t_end("transmit");
        close_out;
    end
endmodule

/* File: inc/ahes_defs.vh */
`ifndef AHES_DEFS_VH
`define AHES_DEFS_VH

// register addresses
`define AHES_ADDR_FRAMER_STAT 8'h00
`define AHES_ADDR_SLIP_CH2_STAT 8'h01
`define AHES_ADDR_FRAMER_MASK 8'h02
`define AHES_ADDR_SLIP_CH2_MASK 8'h03
`define AHES_ADDR_CONFIG 8'h04
`define AHES_ADDR_ES_SRC_MASK 8'h05
`define AHES_ADDR_SUMMARY 8'h06
`define AHES_ADDR_LINE_STAT 8'h07
`define AHES_ADDR_RX_COUNT 8'h08
`define AHES_ADDR_RX_LEN_LO 8'h09
`define AHES_ADDR_RX_LEN_HI 8'h0A
`define AHES_ADDR_RX_ADDR_BYTE 8'h0B
`define AHES_ADDR_RX_FRAME_STAT 8'h0C

// framer_event_status bits
`define AHES_FS_ES 7
`define AHES_FS_SEC 6
`define AHES_FS_LBC 5
`define AHES_FS_RSN 1
`define AHES_FS_RSP 0

// slip_and_channel_two_status bits
`define AHES_SC_XSP 7
`define AHES_SC_XSN 6
`define AHES_SC_RME 5
`define AHES_SC_RFS 4
`define AHES_SC_RDO 3
`define AHES_SC_ALLS 2
`define AHES_SC_XDU 1
`define AHES_SC_RPF 0

// configuration bits
`define AHES_CFG_VIS 0
`define AHES_CFG_PMS 1
`define AHES_CFG_HDLC 2

// errored-second source mask bits
`define AHES_ES_LFA 0
`define AHES_ES_FER 1
`define AHES_ES_CER 2
`define AHES_ES_AIS 3
`define AHES_ES_LOS 4
`define AHES_ES_CVE 5
`define AHES_ES_SLIP 6

// summary bits
`define AHES_SUM_FRAMER 3
`define AHES_SUM_SLIP_CH2 4

// reset values
`define AHES_MASK_RESET 8'hFF
`define AHES_CFG_RESET 8'h04
`define AHES_ES_SRC_RESET 8'h00

// hdlc sizes
`define AHES_POOL_BYTES 6'h20
`define AHES_FRS_DELAY_BYTES 2'h2

// timing
// one second of the 1.544 MHz receive line clock, sized for the 24-bit counter
`define AHES_SEC_TICKS 24'h178F40
// 33.16 ms counted on the 50 MHz system clock
`define AHES_LB_DETECT_CYCLES 24'h194C90

`endif

/* File: rtl/ahes_sec_timer.v */
`timescale 1ns/100ps
`include "ahes_defs.vh"

module ahes_sec_timer #(
    parameter [23:0] SEC_TICKS = `AHES_SEC_TICKS
) (
    input wire i_clk,
    input wire i_resetn,
    input wire i_line_tick,
    input wire [6:0] i_es_src,
    input wire [6:0] i_es_mask,
    output reg o_sec_ff,
    output reg o_es_ff
);
    reg [23:0] cnt_ff;
    reg hit_ff;
    wire expire;
    wire hit_now;

    // counts receive line clock ticks, not the system clock
    assign expire = i_line_tick && (cnt_ff == SEC_TICKS - 24'h000001); // [RULE5]
    assign hit_now = |(i_es_src & i_es_mask); // [RULE3] [RULE4]

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_ff <= 24'h000000;
            hit_ff <= 1'b0;
            o_sec_ff <= 1'b0;
            o_es_ff <= 1'b0;
        end else begin
            o_sec_ff <= expire;
            // an error on the expiring cycle still counts for that interval
            o_es_ff <= expire && (hit_ff || hit_now); // [RULE3]
            if (expire) begin
                cnt_ff <= 24'h000000;
                hit_ff <= 1'b0;
            end else begin
                if (i_line_tick) begin
                    cnt_ff <= cnt_ff + 24'h000001;
                end
                if (hit_now) begin
                    hit_ff <= 1'b1;
                end
            end
        end
    end
endmodule

/* File: rtl/ahes_top.v */
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "ahes_defs.vh"

// Overview of operation
// RULE1: reading either event status register clears all its bits.
// RULE2: visible-masked option records masked events without interrupt or summary.
// RULE3: errored-second flag set if an enabled source fired this second.
// RULE4: source mask covers lfa, framing, crc, blue, red, code violation, slips.
// RULE5: second-timer flag set at each one-second expiry counted from line clock.
// RULE6: select 0: loop-back flag on pattern held 33.16 ms at low error rate.
// RULE7: loop-back flag also set when the detection state is left.
// RULE8: current loop-back detection state readable in the line status register.
// RULE9: receive clock fast: frame skipped, negative receive slip flag; also in simulation.
// RULE10: receive clock slow: frame repeated, positive receive slip flag; also in simulation.
// RULE11: transmit clock slow: positive transmit slip flag; offset needs no rewrite.
// RULE12: transmit clock fast: negative transmit slip flag; offset needs no rewrite.
// RULE13: message-end flag when short frame or final part stored with status.
// RULE14: byte count gives total length; bits 6:0 give receive fifo occupancy.
// RULE15: frame-start flag two bytes after valid start; address and status latched.
// RULE16: lost receive data sets overflow flag; storing resumes once space frees.
// RULE17: overflow flag raised at once; frame status bit covers that frame only.
// RULE18: all-sent flag in hdlc mode when last bit sent and fifo empty.
// RULE19: fifo empty without message-end command: abort frame, set underrun flag.
// RULE20: after underrun transmitter held reset until second status register read.
// RULE21: pool-full flag when 32 bytes of an incomplete frame are stored.
// RULE22: summary holds one bit per status register with unmasked pending events.
// RULE23: interrupt output high while any set status bit is unmasked.

module ahes_top #(
    parameter [23:0] SEC_TICKS = `AHES_SEC_TICKS,
    parameter [23:0] LB_DETECT_CYC = `AHES_LB_DETECT_CYCLES
) (
    input wire I_CLK,
    input wire I_RESETN,
    input wire [7:0] I_ADDR,
    input wire [7:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output reg [7:0] O_RDATA,
    output wire O_INT,
    input wire I_RX_LINE_TICK,
    input wire I_LFA,
    input wire I_FER,
    input wire I_CER,
    input wire I_AIS,
    input wire I_LOS,
    input wire I_CVE,
    input wire I_LB_PATTERN_OK,
    input wire I_PRBS_CHANGE,
    input wire I_ALARM_SIM,
    input wire I_RX_SLIP_NEG,
    input wire I_RX_SLIP_POS,
    input wire I_TX_SLIP_POS,
    input wire I_TX_SLIP_NEG,
    input wire I_CH2_RX_START,
    input wire I_CH2_RX_BYTE,
    input wire I_CH2_RX_END,
    input wire I_CH2_RX_FIFO_FULL,
    input wire [6:0] I_CH2_RX_FIFO_LEVEL,
    input wire [7:0] I_CH2_RX_ADDR,
    input wire [2:0] I_CH2_RX_STATUS,
    output wire O_CH2_RX_STORE,
    input wire I_CH2_TX_NEED_BYTE,
    input wire I_CH2_TX_FIFO_EMPTY,
    input wire I_CH2_TX_MSG_END_CMD,
    input wire I_CH2_TX_LAST_BIT,
    output reg O_CH2_TX_ABORT,
    output wire O_CH2_TX_ENABLE
);
    reg [7:0] fstat_ff;
    reg [7:0] scstat_ff;
    reg [7:0] fmask_ff;
    reg [7:0] scmask_ff;
    reg [7:0] cfg_ff;
    reg [7:0] es_src_ff;
    reg lb_state_ff;
    reg [23:0] lb_cnt_ff;
    reg [11:0] rx_len_ff;
    reg [5:0] pool_cnt_ff;
    reg [1:0] frs_cnt_ff;
    reg frs_wait_ff;
    reg [7:0] rx_addr_ff;
    reg [2:0] rx_stat_ff;
    reg rx_ovf_frame_ff;
    reg tx_xme_ff;
    reg tx_dis_ff;
    reg [7:0] nxt_fstat;
    reg [7:0] nxt_scstat;
    reg [7:0] fev;
    reg [7:0] scev;
    reg [7:0] rd_mux;
    wire vis;
    wire pms;
    wire hdlc_mode;
    wire sec_pulse;
    wire es_pulse;
    wire [6:0] es_src;
    wire lb_event;
    wire rx_drop;
    wire pool_full;
    wire underrun;
    wire rd_fstat;
    wire rd_scstat;
    wire [7:0] summary;

    // gates an event onto the register: masked events survive only with vis set
    function [7:0] record;
        input [7:0] ev;
        input [7:0] mask;
        input vis_on;
        begin
            record = vis_on ? ev : (ev & ~mask);
        end
    endfunction

    // one decoder for both read-to-clear strobes keeps their address match identical
    function rd_hit;
        input rd;
        input [7:0] addr;
        input [7:0] target;
        begin
            rd_hit = rd && (addr == target);
        end
    endfunction

    assign vis = cfg_ff[`AHES_CFG_VIS];
    assign pms = cfg_ff[`AHES_CFG_PMS];
    assign hdlc_mode = cfg_ff[`AHES_CFG_HDLC];

    assign rd_fstat = rd_hit(I_RD, I_ADDR, `AHES_ADDR_FRAMER_STAT); // [RULE1]
    assign rd_scstat = rd_hit(I_RD, I_ADDR, `AHES_ADDR_SLIP_CH2_STAT); // [RULE1]

    // a slip in any direction counts as one errored-second source
    assign es_src = {I_TX_SLIP_POS | I_TX_SLIP_NEG | I_RX_SLIP_POS | I_RX_SLIP_NEG,
                     I_CVE, I_LOS, I_AIS, I_CER, I_FER, I_LFA}; // [RULE4]

    ahes_sec_timer #(
        .SEC_TICKS(SEC_TICKS)
    ) u_sec (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .i_line_tick(I_RX_LINE_TICK),
        .i_es_src(es_src),
        .i_es_mask(es_src_ff[6:0]),
        .o_sec_ff(sec_pulse),
        .o_es_ff(es_pulse)
    );

    // loop-back detection: pattern must hold without a break for the full window
    assign lb_event = pms ? I_PRBS_CHANGE :
                      ((!lb_state_ff && I_LB_PATTERN_OK &&
                        (lb_cnt_ff == LB_DETECT_CYC - 24'h000001)) ||
                       (lb_state_ff && !I_LB_PATTERN_OK)); // [RULE6] [RULE7]

    // a break in the pattern drops the state at once, with no hold-off
    always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            lb_state_ff <= 1'b0;
            lb_cnt_ff <= 24'h000000;
        end else begin
            if (!I_LB_PATTERN_OK) begin
                lb_cnt_ff <= 24'h000000;
                lb_state_ff <= 1'b0; // [RULE7]
            end else if (!lb_state_ff) begin
                if (lb_cnt_ff == LB_DETECT_CYC - 24'h000001) begin
                    lb_state_ff <= 1'b1; // [RULE6]
                    lb_cnt_ff <= 24'h000000;
                end else begin
                    lb_cnt_ff <= lb_cnt_ff + 24'h000001;
                end
            end
        end
    end

    // receive side of channel two
    assign rx_drop = I_CH2_RX_BYTE && I_CH2_RX_FIFO_FULL;
    // storing resumes by itself as soon as the fifo has room again
    assign O_CH2_RX_STORE = I_CH2_RX_BYTE && !I_CH2_RX_FIFO_FULL; // [RULE16]
    assign pool_full = O_CH2_RX_STORE && !I_CH2_RX_END &&
                       (pool_cnt_ff == `AHES_POOL_BYTES - 6'h01); // [RULE21]

    always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rx_len_ff <= 12'h000;
            pool_cnt_ff <= 6'h00;
            frs_cnt_ff <= 2'h0;
            frs_wait_ff <= 1'b0;
            rx_addr_ff <= 8'h00;
            rx_stat_ff <= 3'h0;
            rx_ovf_frame_ff <= 1'b0;
        end else begin
            if (I_CH2_RX_START) begin
                rx_len_ff <= 12'h000;
                pool_cnt_ff <= 6'h00;
                frs_cnt_ff <= 2'h0;
                frs_wait_ff <= 1'b1;
                rx_ovf_frame_ff <= 1'b0; // [RULE17]
            end else begin
                if (I_CH2_RX_BYTE) begin
                    // total length counts every byte of the frame, lost or not
                    rx_len_ff <= rx_len_ff + 12'h001; // [RULE14]
                end
                if (rx_drop) begin
                    rx_ovf_frame_ff <= 1'b1; // [RULE17]
                end
                if (pool_full || I_CH2_RX_END) begin
                    pool_cnt_ff <= 6'h00;
                end else if (O_CH2_RX_STORE) begin
                    pool_cnt_ff <= pool_cnt_ff + 6'h01;
                end
                if (frs_wait_ff && I_CH2_RX_BYTE) begin
                    if (frs_cnt_ff == `AHES_FRS_DELAY_BYTES - 2'h1) begin
                        frs_wait_ff <= 1'b0;
                        rx_addr_ff <= I_CH2_RX_ADDR; // [RULE15]
                        rx_stat_ff <= I_CH2_RX_STATUS; // [RULE15]
                    end
                    frs_cnt_ff <= frs_cnt_ff + 2'h1;
                end
                if (I_CH2_RX_END) begin
                    frs_wait_ff <= 1'b0;
                end
            end
        end
    end

    // transmit side of channel two
    assign underrun = I_CH2_TX_NEED_BYTE && I_CH2_TX_FIFO_EMPTY && !tx_xme_ff &&
                      !tx_dis_ff; // [RULE19]
    assign O_CH2_TX_ENABLE = !tx_dis_ff; // [RULE20]

    always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            tx_xme_ff <= 1'b0;
            tx_dis_ff <= 1'b0;
            O_CH2_TX_ABORT <= 1'b0;
        end else begin
            O_CH2_TX_ABORT <= underrun; // [RULE19]
            if (underrun) begin
                tx_dis_ff <= 1'b1; // [RULE20]
                tx_xme_ff <= 1'b0;
            end else if (rd_scstat) begin
                // a read in the underrun cycle leaves the channel disabled
                tx_dis_ff <= 1'b0; // [RULE20]
            end
            if (!underrun) begin
                if (I_CH2_TX_MSG_END_CMD) begin
                    tx_xme_ff <= 1'b1;
                end else if (I_CH2_TX_LAST_BIT) begin
                    tx_xme_ff <= 1'b0;
                end
            end
        end
    end

    // event collection; the clear by read loses to a same-cycle set
    always @* begin
        fev = 8'h00;
        fev[`AHES_FS_ES] = es_pulse; // [RULE3]
        fev[`AHES_FS_SEC] = sec_pulse; // [RULE5]
        fev[`AHES_FS_LBC] = lb_event; // [RULE6] [RULE7]
        fev[`AHES_FS_RSN] = I_RX_SLIP_NEG || I_ALARM_SIM; // [RULE9]
        fev[`AHES_FS_RSP] = I_RX_SLIP_POS || I_ALARM_SIM; // [RULE10]
        scev = 8'h00;
        // the offset register is left alone on a slip, so no rewrite is needed
        scev[`AHES_SC_XSP] = I_TX_SLIP_POS; // [RULE11]
        scev[`AHES_SC_XSN] = I_TX_SLIP_NEG; // [RULE12]
        scev[`AHES_SC_RME] = I_CH2_RX_END; // [RULE13]
        scev[`AHES_SC_RFS] = frs_wait_ff && I_CH2_RX_BYTE && !I_CH2_RX_START &&
                             (frs_cnt_ff == `AHES_FRS_DELAY_BYTES - 2'h1); // [RULE15]
        scev[`AHES_SC_RDO] = rx_drop; // [RULE16] [RULE17]
        scev[`AHES_SC_ALLS] = hdlc_mode && I_CH2_TX_LAST_BIT && I_CH2_TX_FIFO_EMPTY; // [RULE18]
        scev[`AHES_SC_XDU] = underrun; // [RULE19]
        scev[`AHES_SC_RPF] = pool_full; // [RULE21]
        nxt_fstat = (rd_fstat ? 8'h00 : fstat_ff) | record(fev, fmask_ff, vis); // [RULE1] [RULE2]
        nxt_scstat = (rd_scstat ? 8'h00 : scstat_ff) |
                     record(scev, scmask_ff, vis); // [RULE1] [RULE2]
    end

    // masked bits stay out of the summary and the interrupt even when recorded
    assign summary = {3'h0, |(scstat_ff & ~scmask_ff), |(fstat_ff & ~fmask_ff), 3'h0}; // [RULE22]
    assign O_INT = summary[`AHES_SUM_FRAMER] || summary[`AHES_SUM_SLIP_CH2]; // [RULE23]

    always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            fstat_ff <= 8'h00;
            scstat_ff <= 8'h00;
            fmask_ff <= `AHES_MASK_RESET;
            scmask_ff <= `AHES_MASK_RESET;
            cfg_ff <= `AHES_CFG_RESET;
            es_src_ff <= `AHES_ES_SRC_RESET;
        end else begin
            fstat_ff <= nxt_fstat;
            scstat_ff <= nxt_scstat;
            // the status registers take no writes; only a read clears them
            if (I_WR) begin
                case (I_ADDR)
                    `AHES_ADDR_FRAMER_MASK: begin
                        fmask_ff <= I_WDATA;
                    end
                    `AHES_ADDR_SLIP_CH2_MASK: begin
                        scmask_ff <= I_WDATA;
                    end
                    `AHES_ADDR_CONFIG: begin
                        cfg_ff <= {5'h00, I_WDATA[2:0]};
                    end
                    `AHES_ADDR_ES_SRC_MASK: begin
                        es_src_ff <= {1'b0, I_WDATA[6:0]};
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // read mux; unmapped addresses answer zero
    always @* begin
        case (I_ADDR)
            `AHES_ADDR_FRAMER_STAT: rd_mux = fstat_ff;
            `AHES_ADDR_SLIP_CH2_STAT: rd_mux = scstat_ff;
            `AHES_ADDR_FRAMER_MASK: rd_mux = fmask_ff;
            `AHES_ADDR_SLIP_CH2_MASK: rd_mux = scmask_ff;
            `AHES_ADDR_CONFIG: rd_mux = cfg_ff;
            `AHES_ADDR_ES_SRC_MASK: rd_mux = es_src_ff;
            `AHES_ADDR_SUMMARY: rd_mux = summary; // [RULE22]
            `AHES_ADDR_LINE_STAT: rd_mux = {7'h00, lb_state_ff}; // [RULE8]
            `AHES_ADDR_RX_COUNT: rd_mux = {1'b0, I_CH2_RX_FIFO_LEVEL}; // [RULE14]
            `AHES_ADDR_RX_LEN_LO: rd_mux = rx_len_ff[7:0]; // [RULE14]
            `AHES_ADDR_RX_LEN_HI: rd_mux = {4'h0, rx_len_ff[11:8]};
            `AHES_ADDR_RX_ADDR_BYTE: rd_mux = rx_addr_ff;
            // overflow bit belongs to the frame in progress, unlike the event flag
            `AHES_ADDR_RX_FRAME_STAT: rd_mux = {3'h0, rx_ovf_frame_ff, rx_stat_ff, 1'b0};
            default: rd_mux = 8'h00;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_RDATA <= 8'h00;
        end else begin
            O_RDATA <= I_RD ? rd_mux : 8'h00;
        end
    end
endmodule
